// >>> rtl/dgct_top.v
// Two gated 32-bit counter/timer channels with sampled read-out.
//
// Function
// - Two independent channels, each a 32-bit count, clock, gate and pulse.
// - Channel index 0 selects the first channel, index 1 the second.
// - Listed channel returns low 16-bit half first, then upper half.
// - Listed channel value is sampled once per analog-input sample tick.
// - Internal source uses a programmable divider that sets pulse rate.
// - External source counts clock input; source must stay below 18 MHz.
// - External count advances only on clock input rising edges.
// - Gate type none enables immediately on software start.
// - Low-level gate enables while gate low, disables while high.
// - High-level gate enables while gate high, disables while low.
// - Falling-edge gate enables on a detected high-to-low transition.
// - Rising-edge gate enables on a detected low-to-high transition.
// - High-to-low pulse type makes the low portion active.
// - Low-to-high pulse type makes the high portion active.
// - Programmable duty percentage on the internal source only; 50 gives equal low and high times for an even divider.
`include "dgct_consts.vh"

module dgct_top #(
  parameter NCH = `DGCT_CHANNELS
) (
  // Clock and reset.
  input  wire                      CLK_IN,
  input  wire                      RST_N_IN,
  // Per-channel pins.
  input  wire [NCH-1:0]            CT_CLK_IN,
  input  wire [NCH-1:0]            CT_GATE_IN,
  output wire [NCH-1:0]            CT_PULSE_OUT,
  // Per-channel control, channel n in slice n.
  input  wire [NCH-1:0]            START_IN,
  input  wire [NCH-1:0]            STOP_IN,
  input  wire [NCH-1:0]            CLR_IN,
  input  wire [NCH-1:0]            SRC_SEL_IN,
  input  wire [NCH-1:0]            PULSE_TYPE_IN,
  input  wire [NCH*3-1:0]          GATE_TYPE_IN,
  input  wire [NCH*7-1:0]          DUTY_IN,
  input  wire [NCH*32-1:0]         DIVIDER_IN,
  // Status per channel.
  output wire [NCH-1:0]            RUNNING_OUT,
  output wire [NCH-1:0]            ENABLED_OUT,
  output wire [NCH*32-1:0]         COUNT_OUT,
  // Acquisition list read-out.
  input  wire                      SAMPLE_TICK_IN,
  input  wire                      LIST_VALID_IN,
  input  wire                      LIST_SEL_IN,
  output reg  [`DGCT_HALF_W-1:0]   ACQ_DATA_OUT,
  output reg                       ACQ_VALID_OUT,
  output reg                       ACQ_UPPER_OUT
);

  wire [NCH*32-1:0] count_bus;
  reg  [31:0]       snap;
  reg               upper_pending;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      reg  [2:0]  clk_sync;
      reg  [2:0]  gate_sync;
      reg         clk_lvl;
      reg         gate_lvl;
      reg         running;
      reg         latched;
      reg         enabled;
      reg  [31:0] count;
      reg  [31:0] div_cnt;
      reg         pulse;
      wire [2:0]  gtype = GATE_TYPE_IN[g*3 +: 3];
      wire [6:0]  duty  = DUTY_IN[g*7 +: 7];
      wire [31:0] div   = DIVIDER_IN[g*32 +: 32];
      reg         next_clk_lvl;
      reg         next_gate_lvl;
      reg         gate_ok;
      reg         tick;
      reg  [38:0] act_prod;
      reg  [38:0] pos_prod;
      reg         active;

      // A level changes only once the second and third stages agree, so
      // a metastable first stage never reaches any decision logic.
      always @* begin
        next_clk_lvl  = clk_lvl;
        next_gate_lvl = gate_lvl;
        if (clk_sync[1] == clk_sync[2])
          next_clk_lvl = clk_sync[2];
        if (gate_sync[1] == gate_sync[2])
          next_gate_lvl = gate_sync[2];
      end

      always @* begin
        case (gtype)
          `DGCT_GATE_NONE: gate_ok = 1'b1;
          `DGCT_GATE_LOW:  gate_ok = ~gate_lvl;
          `DGCT_GATE_HIGH: gate_ok = gate_lvl;
          `DGCT_GATE_FALL: gate_ok = latched;
          `DGCT_GATE_RISE: gate_ok = latched;
          default:         gate_ok = 1'b0;
        endcase
        if (SRC_SEL_IN[g] == `DGCT_SRC_EXT)
          tick = next_clk_lvl & ~clk_lvl;
        else
          tick = (div_cnt >= div - 32'h00000001);
        // Active while position/period is below duty/100; no divide needed.
        pos_prod = {7'h00, div_cnt} * {32'h00000000, `DGCT_PCT_FULL};
        act_prod = {7'h00, div} * {32'h00000000, duty};
        active   = running & enabled & (pos_prod < act_prod);
      end

      always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          clk_sync  <= 3'h0;
          gate_sync <= 3'h0;
          clk_lvl   <= 1'b0;
          gate_lvl  <= 1'b0;
          running   <= 1'b0;
          latched   <= 1'b0;
          enabled   <= 1'b0;
          count     <= `DGCT_RST_COUNT;
          div_cnt   <= 32'h00000000;
          pulse     <= 1'b0;
        end else begin
          clk_sync  <= {clk_sync[1:0], CT_CLK_IN[g]};
          gate_sync <= {gate_sync[1:0], CT_GATE_IN[g]};
          clk_lvl   <= next_clk_lvl;
          gate_lvl  <= next_gate_lvl;
          if (STOP_IN[g]) begin
            running <= 1'b0;
            latched <= 1'b0;
          end else if (START_IN[g]) begin
            running <= 1'b1;
            latched <= 1'b0;
          end else if (running) begin
            if (gtype == `DGCT_GATE_FALL && gate_lvl && !next_gate_lvl)
              latched <= 1'b1;
            if (gtype == `DGCT_GATE_RISE && !gate_lvl && next_gate_lvl)
              latched <= 1'b1;
          end
          enabled <= running & gate_ok;
          if (CLR_IN[g])
            count <= `DGCT_RST_COUNT;
          else if (running && enabled && tick)
            count <= count + 32'h00000001;
          if (!running || SRC_SEL_IN[g] == `DGCT_SRC_EXT)
            div_cnt <= 32'h00000000;
          else if (enabled)
            div_cnt <= tick ? 32'h00000000 : div_cnt + 32'h00000001;
          // Idle level is low for either polarity, as the output is forced low while not running.
          if (PULSE_TYPE_IN[g] == `DGCT_PULSE_L2H)
            pulse <= active;
          else
            pulse <= ~active & running;
        end
      end

      assign CT_PULSE_OUT[g]      = pulse;
      assign RUNNING_OUT[g]       = running;
      assign ENABLED_OUT[g]       = enabled;
      assign count_bus[g*32 +: 32] = count;
    end
  endgenerate

  assign COUNT_OUT = count_bus;

  // The whole word is captured on the tick so both halves are coherent.
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      snap          <= `DGCT_RST_COUNT;
      upper_pending <= 1'b0;
      ACQ_DATA_OUT  <= 16'h0000;
      ACQ_VALID_OUT <= 1'b0;
      ACQ_UPPER_OUT <= 1'b0;
    end else begin
      ACQ_VALID_OUT <= 1'b0;
      ACQ_UPPER_OUT <= 1'b0;
      if (SAMPLE_TICK_IN && LIST_VALID_IN) begin
        snap          <= count_bus[LIST_SEL_IN*32 +: 32];
        ACQ_DATA_OUT  <= count_bus[LIST_SEL_IN*32 +: 16];
        ACQ_VALID_OUT <= 1'b1;
        upper_pending <= 1'b1;
      end else if (upper_pending) begin
        ACQ_DATA_OUT  <= snap[31:16];
        ACQ_VALID_OUT <= 1'b1;
        ACQ_UPPER_OUT <= 1'b1;
        upper_pending <= 1'b0;
      end
    end
  end

endmodule

// >>> pkg/dgct_consts.vh
// Constants for the dual gated counter/timer.
`ifndef DGCT_CONSTS_VH
`define DGCT_CONSTS_VH

`define DGCT_CHANNELS      2
`define DGCT_COUNT_W       32
`define DGCT_HALF_W        16
`define DGCT_PCT_W         7
`define DGCT_DIV_W         32
`define DGCT_RST_COUNT     32'h00000000
`define DGCT_RST_DIV       32'h00000002
`define DGCT_RST_DUTY      7'h32
`define DGCT_PCT_FULL      7'h64
`define DGCT_CLK_HZ        125000000
`define DGCT_EXT_MAX_HZ    18000000

`define DGCT_GATE_NONE     3'h0
`define DGCT_GATE_LOW      3'h1
`define DGCT_GATE_HIGH     3'h2
`define DGCT_GATE_FALL     3'h3
`define DGCT_GATE_RISE     3'h4

`define DGCT_SRC_INT       1'h0
`define DGCT_SRC_EXT       1'h1
`define DGCT_PULSE_H2L     1'h0
`define DGCT_PULSE_L2H     1'h1

`endif

// >>> verification/dgct_clk_src.sv
// External count clock source model for one channel pin.
module dgct_clk_src (
  input  wire logic clk_in,
  input  wire logic run_in,
  output wire logic ct_clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase;
  // Eight cycles a period keeps the source below the 18 MHz ceiling.
  always @(posedge clk_in) phase <= run_in ? phase + 3'h1 : 3'h0;
  assign ct_clk_out = phase[2];
endmodule

// >>> verification/dgct_checker.sv
// Port assertions for the counter/timer.
module dgct_checker #(parameter NCH = 2) (
  input wire logic              CLK_IN, RST_N_IN, SAMPLE_TICK_IN,
  input wire logic              LIST_VALID_IN, LIST_SEL_IN,
  input wire logic [NCH-1:0]    START_IN, STOP_IN, CLR_IN, RUNNING_OUT,
  input wire logic [NCH-1:0]    ENABLED_OUT, CT_PULSE_OUT,
  input wire logic [NCH*3-1:0]  GATE_TYPE_IN,
  input wire logic [NCH*32-1:0] COUNT_OUT,
  input wire logic [15:0]       ACQ_DATA_OUT,
  input wire logic              ACQ_VALID_OUT, ACQ_UPPER_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire tk = SAMPLE_TICK_IN && LIST_VALID_IN;
  wire [15:0] lo = LIST_SEL_IN ? COUNT_OUT[47:32] : COUNT_OUT[15:0];
  wire [31:0] c0 = COUNT_OUT[31:0];
  property p_start;
    START_IN[0] && !STOP_IN[0] |=> RUNNING_OUT[0];
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_none;
    RUNNING_OUT[0] && !STOP_IN[0] && GATE_TYPE_IN[2:0] == 3'h0
      |=> ENABLED_OUT[0];
  endproperty
  a_none: assert property (p_none) else $error("not enabled");
  property p_lo;
    tk |=> ACQ_VALID_OUT && !ACQ_UPPER_OUT;
  endproperty
  a_lo: assert property (p_lo) else $error("no low word");
  property p_hi;
    tk ##1 !tk |=> ACQ_VALID_OUT && ACQ_UPPER_OUT;
  endproperty
  a_hi: assert property (p_hi) else $error("no upper word");
  property p_data;
    tk |=> ACQ_DATA_OUT == $past(lo);
  endproperty
  a_data: assert property (p_data) else $error("bad low word");
  property p_idle;
    !RUNNING_OUT[0] [*3] |-> !CT_PULSE_OUT[0];
  endproperty
  a_idle: assert property (p_idle) else $error("pulse idle");
  property p_step;
    c0 != $past(c0) |-> c0 == $past(c0) + 32'h1 || c0 == 32'h0;
  endproperty
  a_step: assert property (p_step) else $error("count jump");
  property p_hold;
    !ENABLED_OUT[0] [*2] ##0 !CLR_IN[0] |=> $stable(c0);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  c_en: cover property (ENABLED_OUT[1]);
  c_hi: cover property (ACQ_UPPER_OUT);
  c_pl: cover property (CT_PULSE_OUT[0]);
endmodule
bind dgct_top dgct_checker #(.NCH(NCH)) dgct_checker_i (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .SAMPLE_TICK_IN(SAMPLE_TICK_IN),
  .LIST_VALID_IN(LIST_VALID_IN), .LIST_SEL_IN(LIST_SEL_IN),
  .START_IN(START_IN), .STOP_IN(STOP_IN), .CLR_IN(CLR_IN),
  .RUNNING_OUT(RUNNING_OUT), .ENABLED_OUT(ENABLED_OUT),
  .CT_PULSE_OUT(CT_PULSE_OUT), .GATE_TYPE_IN(GATE_TYPE_IN),
  .COUNT_OUT(COUNT_OUT), .ACQ_DATA_OUT(ACQ_DATA_OUT),
  .ACQ_VALID_OUT(ACQ_VALID_OUT), .ACQ_UPPER_OUT(ACQ_UPPER_OUT));

// >>> verification/tb.sv
// Self-checking bench for the counter/timer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, run = 0, tick = 0, lv = 0, lsel = 0;
  logic [1:0] gate = 2'h0, start = 2'h0, stop = 2'h0, clr = 2'h0;
  logic [1:0] src = 2'h0, ptype = 2'h1, pulse, running, enabled;
  logic [5:0] gtype = 6'h0;
  logic [13:0] duty = 14'h19;
  logic [63:0] div = {32'h4, 32'h4}, count;
  logic [15:0] adata;
  logic avalid, aupper, xclk;
  int err_total = 0, tests_run = 0, cycles = 0;
  dgct_clk_src dgct_clk_src_i (.clk_in(clk), .run_in(run), .ct_clk_out(xclk));
  dgct_top dgct_top_i (.CLK_IN(clk), .RST_N_IN(rst_n),
    .CT_CLK_IN({xclk, 1'b0}), .CT_GATE_IN(gate), .CT_PULSE_OUT(pulse),
    .START_IN(start), .STOP_IN(stop), .CLR_IN(clr), .SRC_SEL_IN(src),
    .PULSE_TYPE_IN(ptype), .GATE_TYPE_IN(gtype), .DUTY_IN(duty),
    .DIVIDER_IN(div), .RUNNING_OUT(running), .ENABLED_OUT(enabled),
    .COUNT_OUT(count), .SAMPLE_TICK_IN(tick), .LIST_VALID_IN(lv),
    .LIST_SEL_IN(lsel), .ACQ_DATA_OUT(adata), .ACQ_VALID_OUT(avalid),
    .ACQ_UPPER_OUT(aupper));
  initial forever #4 clk = ~clk;
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      give_verdict;
    end
  end
  task automatic m_duty(input logic pt, input logic [6:0] d, int e);
    int hi;
    @(posedge clk) begin ptype[0] <= pt; duty[6:0] <= d; end
    w(8);
    hi = 0;
    repeat (40) @(negedge clk) hi += pulse[0];
    chk(hi, e);
  endtask
  task automatic t_int;
    logic [31:0] c0;
    @(negedge clk) chk({running, enabled, pulse}, 6'h00);
    chk(count[31:0], 32'h0);
    chk(count[63:32], 32'h0);
    @(posedge clk) start <= 2'h1;
    @(posedge clk) start <= 2'h0;
    w(12);
    @(negedge clk) chk(enabled[0], 1'b1);
    c0 = count[31:0];
    repeat (40) @(negedge clk);
    chk(count[31:0], c0 + 32'ha);
    m_duty(1'b1, 7'h19, 10);
    m_duty(1'b0, 7'h19, 30);
    m_duty(1'b1, 7'h32, 20);
  endtask
  // Edge gates here stand for edge-to-edge and one-shot style use.
  task automatic t_gate(input logic [2:0] ty, input logic g0, g1);
    @(posedge clk) begin stop <= 2'h1; gtype[2:0] <= ty; gate[0] <= g0; end
    @(posedge clk) begin stop <= 2'h0; start <= 2'h1; end
    @(posedge clk) start <= 2'h0;
    w(8);
    @(negedge clk) chk(enabled[0], 1'b0);
    @(posedge clk) gate[0] <= g1;
    w(8);
    @(negedge clk) chk(enabled[0], 1'b1);
  endtask
  task automatic t_ext;
    // Level gate paired with external event counting.
    @(posedge clk) begin src[1] <= 1'b1; gtype[5:3] <= 3'h1; end
    @(posedge clk) begin gate[1] <= 1'b1; start <= 2'h2; clr <= 2'h2; end
    @(posedge clk) begin start <= 2'h0; clr <= 2'h0; end
    w(8);
    @(posedge clk) run <= 1'b1;
    w(64);
    @(negedge clk) chk(count[63:32], 32'h0);
    chk({running[1], enabled[1], pulse[1]}, 3'h5);
    @(posedge clk) begin run <= 1'b0; gate[1] <= 1'b0; end
    w(8);
    @(posedge clk) run <= 1'b1;
    w(64);
    @(posedge clk) run <= 1'b0;
    w(10);
    @(negedge clk) chk(count[63:32], 32'h8);
    chk({running[1], enabled[1]}, 2'h3);
    @(posedge clk) stop <= 2'h2;
    @(posedge clk) begin stop <= 2'h0; tick <= 1'b1; lv <= 1'b1; end
    @(posedge clk) begin tick <= 1'b0; lsel <= 1'b1; end
    w(2);
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    @(negedge clk) chk({avalid, aupper, adata}, {2'h2, 16'h8});
    @(negedge clk) chk({avalid, aupper, adata}, {2'h3, 16'h0});
  endtask
  initial begin
    w(20);
    rst_n <= 1'b1;
    w(1);
    t_int;
    t_gate(3'h1, 1'b1, 1'b0);
    t_gate(3'h2, 1'b0, 1'b1);
    t_gate(3'h3, 1'b1, 1'b0);
    t_gate(3'h4, 1'b0, 1'b1);
    t_ext;
    give_verdict;
  end
endmodule
